// file: inc/pef_pkg.sv
// Package of offsets, field positions and encodings for the event flag block.
package pef_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] PEF_OFS_FLAGS = 12'h000;
	localparam logic [11:0] PEF_OFS_ENABLE = 12'h004;
	localparam logic [11:0] PEF_OFS_STATUS = 12'h008;
	localparam logic [11:0] PEF_OFS_CLEAR = 12'h00c;
	localparam logic [11:0] PEF_OFS_CONFIG = 12'h010;

	// ==========================================================
	// Flag bit positions
	localparam int PEF_BIT_OVF = 0;
	localparam int PEF_BIT_PER = 1;
	localparam int PEF_BIT_CCP = 2;
	localparam int PEF_BIT_SER = 3;
	localparam int PEF_BIT_PAR = 7;
	localparam int PEF_NFLAGS = 8;

	// ==========================================================
	// Reset values
	localparam logic [7:0] PEF_FLAGS_RST = 8'h00;
	localparam logic [7:0] PEF_ENABLE_RST = 8'h00;
	localparam logic [0:0] PEF_PARPORT_RST = 1'h0;
	localparam logic [31:0] PEF_UNMAPPED_DATA = 32'h00000000;

	// ==========================================================
	// Capture/compare unit modes
	typedef enum logic [1:0] {
		PEF_CCP_OFF,
		PEF_CCP_CAPTURE,
		PEF_CCP_COMPARE,
		PEF_CCP_PWM
	} pef_ccp_mode_type;

	// Serial unit mode, used for the master-only START and repeated start flags
	typedef enum logic [1:0] {
		PEF_SER_SPI,
		PEF_SER_I2C_SLAVE,
		PEF_SER_I2C_MASTER
	} pef_ser_mode_type;

endpackage : pef_pkg

// file: hdl/pef_flag_bit.sv
// One sticky event flag with set priority over clear and write.
`timescale 1ns/10ps
`default_nettype none
module pef_flag_bit (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic set_in,
	input wire logic clr_in,
	input wire logic wr_en_in,
	input wire logic wr_val_in,
	output logic flag_out
);
	import pef_pkg::*;

	typedef struct packed {
		logic flag;
	} pef_bit_state_type;

	pef_bit_state_type st_ff;
	pef_bit_state_type nxt_st;

	// ==========================================================
	// Next state
	always_comb begin
		nxt_st = st_ff;
		if (wr_en_in) begin
			nxt_st.flag = wr_val_in;
		end
		if (clr_in) begin
			nxt_st.flag = 1'b0;
		end
		// A hardware event in the clearing cycle is never lost.
		if (set_in) begin
			nxt_st.flag = 1'b1; // RULE13
		end
	end

	// ==========================================================
	// Register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign flag_out = st_ff.flag;
endmodule : pef_flag_bit
`default_nettype wire

// file: hdl/pef_flags.sv
// Peripheral event flag register, lower half plus parallel-port flag, on APB.
// What this block does
// RULE1: Serial flag bit 3 sets on transfer done in SPI, I2C slave or master.
// RULE2: Serial flag sets when our own I2C START generation completes.
// RULE3: Serial flag sets when our own repeated start generation completes.
// RULE4: Serial flag sets on bus START seen while serial unit idle.
// RULE5: Serial flag sets on bus STOP seen while serial unit idle.
// RULE6: Software clears serial flag before leaving handler; hardware never does.
// RULE7: Capture mode: bit 2 sets on each counter capture, sticky.
// RULE8: Compare mode: bit 2 sets on counter match, sticky; unused in PWM.
// RULE9: Bit 1 sets when eight-bit timer equals period value, sticky; the code sets it only on the first cycle of each match.
// RULE10: Bit 0 sets when sixteen-bit counter rolls over, sticky.
// RULE11: Without parallel port, software keeps bit 7 zero.
// RULE12: Bit 7 sets after any external host read or write.
// RULE13: Event in same cycle as clearing write leaves flag set.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pef_flags (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic ser_xfer_done_in,
	input wire pef_pkg::pef_ser_mode_type ser_mode_in,
	input wire logic ser_start_done_in,
	input wire logic ser_restart_done_in,
	input wire logic ser_busy_in,
	input wire logic bus_start_seen_in,
	input wire logic bus_stop_seen_in,
	input wire pef_pkg::pef_ccp_mode_type ccp_mode_in,
	input wire logic ccp_capture_in,
	input wire logic ccp_match_in,
	input wire logic [7:0] timer_value_in,
	input wire logic [7:0] timer_period_value_in,
	input wire logic counter_rollover_in,
	input wire logic par_host_access_in,
	output logic [7:0] flags_out,
	output logic irq_out
);
	import pef_pkg::*;

	typedef struct packed {
		logic [7:0] enable;
		logic parport_present;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic [7:0] flags_copy;
		logic irq;
		logic per_match_prev;
	} pef_state_type;

	pef_state_type st_ff;
	pef_state_type nxt_st;
	logic [7:0] flags;
	logic [7:0] set_vec;
	logic [7:0] clr_vec;
	logic wr_flags;
	logic per_match;
	logic ser_idle;
	logic access;
	logic mapped;

	// ==========================================================
	// Bus decode
	assign access = psel_in && penable_in && !st_ff.ready;
	assign mapped = (paddr_in == PEF_OFS_FLAGS) ||
		(paddr_in == PEF_OFS_ENABLE) || (paddr_in == PEF_OFS_STATUS) ||
		(paddr_in == PEF_OFS_CLEAR) || (paddr_in == PEF_OFS_CONFIG);
	assign wr_flags = access && pwrite_in && pstrb_in[0] &&
		(paddr_in == PEF_OFS_FLAGS);

	// ==========================================================
	// Event sources
	// The match is level; only its rising edge counts so a stalled timer
	// sitting at the period value does not keep re-arming the flag.
	assign per_match = (timer_value_in == timer_period_value_in);
	assign ser_idle = !ser_busy_in;

	always_comb begin
		set_vec = '0;
		clr_vec = '0;
		set_vec[PEF_BIT_OVF] = counter_rollover_in; // RULE10
		set_vec[PEF_BIT_PER] = per_match && !st_ff.per_match_prev; // RULE9
		set_vec[PEF_BIT_CCP] =
			(ccp_mode_in == PEF_CCP_CAPTURE && ccp_capture_in) || // RULE7
			(ccp_mode_in == PEF_CCP_COMPARE && ccp_match_in); // RULE8
		set_vec[PEF_BIT_SER] = ser_xfer_done_in || // RULE1
			(ser_mode_in == PEF_SER_I2C_MASTER &&
			(ser_start_done_in || // RULE2
			ser_restart_done_in)) || // RULE3
			(ser_idle && bus_start_seen_in) || // RULE4
			(ser_idle && bus_stop_seen_in); // RULE5
		// Without a parallel port the bit never sets from hardware.
		set_vec[PEF_BIT_PAR] = par_host_access_in &&
			st_ff.parport_present; // RULE12
		if (access && pwrite_in && pstrb_in[0] &&
			paddr_in == PEF_OFS_CLEAR) begin
			clr_vec = pwdata_in[7:0];
		end
	end

	// ==========================================================
	// Flag bits; hardware events set them, only software writes or clears them.
	genvar gi;
	generate
		for (gi = 0; gi < PEF_NFLAGS; gi++) begin : g_flag
			if (gi == PEF_BIT_OVF || gi == PEF_BIT_PER ||
				gi == PEF_BIT_CCP || gi == PEF_BIT_SER ||
				gi == PEF_BIT_PAR) begin : g_impl
				pef_flag_bit u_bit (
					.clk_in(clk_in),
					.rst_in(rst_in),
					.set_in(set_vec[gi]),
					.clr_in(clr_vec[gi]),
					.wr_en_in(wr_flags),
					.wr_val_in(pwdata_in[gi]),
					.flag_out(flags[gi])
				); // RULE6
			end else begin : g_none
				assign flags[gi] = 1'b0;
			end
		end
	endgenerate

	// ==========================================================
	// Register file and outputs
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ready = access;
		nxt_st.err = access && !mapped;
		nxt_st.per_match_prev = per_match;
		if (access && !pwrite_in) begin
			unique case (paddr_in)
				PEF_OFS_FLAGS: nxt_st.rdata = {24'h000000, flags};
				PEF_OFS_ENABLE: nxt_st.rdata = {24'h000000, st_ff.enable};
				PEF_OFS_STATUS: nxt_st.rdata = {24'h000000, flags};
				PEF_OFS_CONFIG: nxt_st.rdata = {31'h00000000,
					st_ff.parport_present};
				default: nxt_st.rdata = PEF_UNMAPPED_DATA;
			endcase
		end else if (!access) begin
			nxt_st.rdata = '0;
		end
		if (access && pwrite_in && pstrb_in[0]) begin
			if (paddr_in == PEF_OFS_ENABLE) begin
				nxt_st.enable = pwdata_in[7:0];
			end
			if (paddr_in == PEF_OFS_CONFIG) begin
				nxt_st.parport_present = pwdata_in[0]; // RULE11
			end
		end
		nxt_st.flags_copy = flags;
		nxt_st.irq = |(flags & st_ff.enable);
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_ff <= '0;
			st_ff.enable <= PEF_ENABLE_RST;
			st_ff.parport_present <= PEF_PARPORT_RST;
			st_ff.flags_copy <= PEF_FLAGS_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prdata_out = st_ff.rdata;
	assign pready_out = st_ff.ready;
	assign pslverr_out = st_ff.err;
	assign flags_out = st_ff.flags_copy;
	assign irq_out = st_ff.irq;
endmodule : pef_flags
`default_nettype wire

// file: tb/pef_flags_properties.sv
// Port timing checker for the event flag block.
`timescale 1ns/10ps
`default_nettype none
module pef_flags_chk
import pef_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic ser_xfer_done_in,
	input wire logic ser_busy_in,
	input wire logic bus_start_seen_in,
	input wire pef_ccp_mode_type ccp_mode_in,
	input wire logic ccp_capture_in,
	input wire logic counter_rollover_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [7:0] flags_out,
	input wire logic irq_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_ovf; counter_rollover_in |-> ##2 flags_out[0]; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag late");
	// Flag bit 0 may only drop two edges after a taken write.
	property p_fell;
		$fell(flags_out[0]) |-> $past(psel_in && penable_in && pwrite_in, 2);
	endproperty
	a_fell: assert property (p_fell) else $error("flag lost");
	property p_ser; ser_xfer_done_in |-> ##2 flags_out[3]; endproperty
	a_ser: assert property (p_ser) else $error("serial flag late");
	property p_idle; bus_start_seen_in && !ser_busy_in |-> ##2 flags_out[3];
	endproperty
	a_idle: assert property (p_idle) else $error("start flag late");
	property p_cap;
		ccp_capture_in && ccp_mode_in == PEF_CCP_CAPTURE |-> ##2 flags_out[2];
	endproperty
	a_cap: assert property (p_cap) else $error("capture flag late");
	property p_rdy; psel_in && penable_in && !pready_out |=> pready_out;
	endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_err; pslverr_out |-> pready_out; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_irq; irq_out |-> flags_out != 8'h00; endproperty
	a_irq: assert property (p_irq) else $error("irq without flag");
endmodule : pef_flags_chk
bind pef_flags pef_flags_chk u_chk (.*);
`default_nettype wire

// file: tb/pef_periph_model.sv
// Timer and counter model that feeds the event flag block.
`timescale 1ns/10ps
`default_nettype none
module pef_periph_model #(parameter int CW = 4) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic run_in,
	input wire logic [7:0] period_in,
	output logic [7:0] timer_out,
	output logic roll_out
);
	// A short counter keeps rollovers frequent in simulation.
	logic [CW-1:0] cnt_ff;
	assign roll_out = run_in && (&cnt_ff);
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_ff <= '0;
			timer_out <= 8'h00;
		end else if (run_in) begin
			cnt_ff <= cnt_ff + 1'b1;
			timer_out <= timer_out == period_in ? 8'h00 : timer_out + 8'h01;
		end
	end
endmodule : pef_periph_model
`default_nettype wire

// file: tb/tb_pef_flags.sv
// Self-checking bench of the event flag block.
`timescale 1ns/10ps
`default_nettype none
module tb_pef_flags;
import pef_pkg::*;
	logic clk_in = 0, rst_in = 1, psel = 0, pen = 0, pwr = 0, busy = 0;
	logic run = 0, rdy, err, irq, roll;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, prd, r;
	logic [7:0] ev = 8'h00, per = 8'h05, tv, fo;
	logic [7:0] ex [10] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h04,
		8'h04, 8'h80, 8'h00, 8'h00};
	logic [16:0] q[$], e;
	pef_ser_mode_type sm = PEF_SER_SPI;
	pef_ccp_mode_type cm = PEF_CCP_OFF;
	int n_fail = 0, checks_done = 0;
	always #25 clk_in = ~clk_in;
	pef_flags u_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
		.pstrb_in(4'hf), .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
		.ser_xfer_done_in(ev[0]), .ser_mode_in(sm), .ser_start_done_in(ev[1]),
		.ser_restart_done_in(ev[2]), .ser_busy_in(busy),
		.bus_start_seen_in(ev[3]), .bus_stop_seen_in(ev[4]), .ccp_mode_in(cm),
		.ccp_capture_in(ev[5]), .ccp_match_in(ev[6]), .timer_value_in(tv),
		.timer_period_value_in(per), .counter_rollover_in(roll),
		.par_host_access_in(ev[7]), .flags_out(fo), .irq_out(irq));
	pef_periph_model u_per (.clk_in(clk_in), .rst_in(rst_in), .run_in(run),
		.period_in(per), .timer_out(tv), .roll_out(roll));
	task chk(input logic c);
		if (c !== 1'b1) begin
			$display("unexpected at %0t: value mismatch", $time);
			n_fail++;
		end
		checks_done++;
	endtask : chk
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk_in);
		pen <= 1;
		do @(posedge clk_in); while (rdy !== 1'b1);
		psel <= 0;
		pen <= 0;
	endtask : apb
	task rd(input logic [11:0] a, input logic [7:0] m, x, input logic f);
		q.push_back({f, m, x & m});
		apb(0, a, 32'h0);
	endtask : rd
	// Reads are judged where the answer appears, not in the driver.
	always @(posedge clk_in) if (rdy === 1'b1 && !pwr) begin
		e = q.pop_front();
		chk({err, prd[31:8], prd[7:0] & e[15:8]} === {e[16], 24'h0, e[7:0]});
	end
	initial begin
		repeat (3000) @(posedge clk_in);
		n_fail++;
		close_out;
	end
	initial begin
		void'($urandom(93540));
		repeat (4) @(posedge clk_in);
		rst_in <= 0;
		rd(PEF_OFS_FLAGS, 8'hff, 8'h00, 0);
		rd(PEF_OFS_ENABLE, 8'hff, 8'h00, 0);
		rd(12'h0f0, 8'hff, 8'h00, 1);
		apb(1, PEF_OFS_CONFIG, 32'h1);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_in);
			sm <= i inside {1, 2} ? PEF_SER_I2C_MASTER
				: pef_ser_mode_type'($urandom_range(2));
			cm <= i == 5 ? PEF_CCP_CAPTURE : i == 6 ? PEF_CCP_COMPARE : PEF_CCP_PWM;
			busy <= i == 9;
			ev <= 8'h01 << (i == 8 ? 5 : i == 9 ? 3 : i);
			@(posedge clk_in);
			ev <= 8'h00;
			rd(PEF_OFS_STATUS, 8'hff, ex[i], 0);
			apb(1, PEF_OFS_CLEAR, 32'hff);
		end
		// The event lands on the very edge that takes the clearing write.
		fork
			apb(1, PEF_OFS_CLEAR, 32'hff);
			begin
				repeat (2) @(posedge clk_in);
				ev <= 8'h01;
				@(posedge clk_in);
				ev <= 8'h00;
			end
		join
		rd(PEF_OFS_STATUS, 8'hff, 8'h08, 0);
		apb(1, PEF_OFS_CLEAR, 32'hff);
		apb(1, PEF_OFS_CONFIG, 32'h0);
		@(posedge clk_in);
		ev <= 8'h80;
		@(posedge clk_in);
		ev <= 8'h00;
		rd(PEF_OFS_STATUS, 8'hff, 8'h00, 0);
		per <= 8'($urandom_range(9, 3));
		run <= 1;
		repeat (40) @(posedge clk_in);
		run <= 0;
		rd(PEF_OFS_STATUS, 8'h03, 8'h03, 0);
		repeat (2) @(posedge clk_in);
		chk(irq === 1'b0);
		apb(1, PEF_OFS_ENABLE, 32'h2);
		repeat (2) @(posedge clk_in);
		chk(irq === 1'b1);
		apb(1, PEF_OFS_CLEAR, 32'h3);
		repeat (2) @(posedge clk_in);
		chk(irq === 1'b0);
		r = $urandom;
		apb(1, PEF_OFS_FLAGS, r);
		rd(PEF_OFS_FLAGS, 8'hff, r[7:0] & 8'h8f, 0);
		repeat (2) @(posedge clk_in);
		chk(fo === (r[7:0] & 8'h8f));
		close_out;
	end
endmodule : tb_pef_flags
`default_nettype wire
